// ---- design/dcig_consts.vh ----
// Constants for the control-input gating front end: offsets, fields, encodings
`ifndef DCIG_CONSTS_VH
`define DCIG_CONSTS_VH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define DCIG_ADDR_W 12
`define DCIG_OFF_MODE 12'h000
`define DCIG_OFF_STATUS 12'h004
`define DCIG_OFF_CMDCNT 12'h008
`define DCIG_OFF_MASKCNT 12'h00C

// ----------------------------------------------------------------------
// Mode register fields
// ----------------------------------------------------------------------
`define DCIG_MODE_RST 11'h000
`define DCIG_MODE_W 11
`define DCIG_F_TERM_DIS 0
`define DCIG_F_BL_LO 1
`define DCIG_F_BL_HI 2
`define DCIG_F_BT 3
`define DCIG_F_AL_LO 4
`define DCIG_F_AL_HI 5
`define DCIG_F_RL_LO 6
`define DCIG_F_RL_HI 10

// Burst length selections
`define DCIG_BL_FIXED8 2'h0
`define DCIG_BL_OTF 2'h1
`define DCIG_BL_FIXED4 2'h2

// Additive latency selections
`define DCIG_AL_ZERO 2'h0
`define DCIG_AL_RL_M1 2'h1
`define DCIG_AL_RL_M2 2'h2
`define DCIG_RL_ONE 5'h01
`define DCIG_RL_TWO 5'h02

// ----------------------------------------------------------------------
// Commands {act_n, ras, cas, we} with chip select already low
// ----------------------------------------------------------------------
`define DCIG_CMD_MRS 4'h8
`define DCIG_CMD_REF 4'h9
`define DCIG_CMD_PRE 4'hA
`define DCIG_CMD_WR 4'hC
`define DCIG_CMD_RD 4'hD

// Power states
`define DCIG_ST_NORMAL 2'h0
`define DCIG_ST_PPD 2'h1
`define DCIG_ST_APD 2'h2
`define DCIG_ST_SREF 2'h3

// Synchronised pin vector width
`define DCIG_PIN_W 17
`define DCIG_CNT_RST 32'h00000000

`endif

// ---- design/dcig_top.v ----
// Control-input gating front end of a x16 DDR4 SDRAM, with APB register slave
`timescale 1ns/1ps
`include "dcig_consts.vh"

module dcig_top
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`DCIG_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire clock_true,
  input wire clock_complement,
  input wire clock_gate,
  input wire chip_select_n,
  input wire activate_n,
  input wire [2:0] cmd_bits,
  input wire bank_group,
  input wire [1:0] bank_addr,
  input wire addr_ap,
  input wire addr_bc_n,
  input wire [2:0] addr_col,
  input wire termination_enable,
  output reg internal_clk_run,
  output reg output_drv_en,
  output reg clk_buf_en,
  output reg ctl_buf_en,
  output reg term_buf_en,
  output reg [1:0] power_state,
  output reg nominal_termination,
  output reg cmd_valid,
  output reg [3:0] cmd_code,
  output reg [1:0] group_io_en,
  output reg burst_chop_four,
  output reg [23:0] burst_order,
  output reg [4:0] additive_latency
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  wire [`DCIG_PIN_W-1:0] pin_raw;
  reg [`DCIG_PIN_W-1:0] pin_m_q;
  reg [`DCIG_PIN_W-1:0] pin_s_q;
  reg ck_t_prev_q;
  reg ck_c_prev_q;
  reg cke_prev_q;

  assign pin_raw = {termination_enable, addr_col, addr_bc_n, addr_ap, bank_group, bank_addr,
                    activate_n, cmd_bits, chip_select_n, clock_gate, clock_complement,
                    clock_true};

  // Two flops for every pin; only the second stage is looked at
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_m_q <= {`DCIG_PIN_W{1'b0}};
      pin_s_q <= {`DCIG_PIN_W{1'b0}};
      ck_t_prev_q <= 1'b0;
      ck_c_prev_q <= 1'b0;
    end
    else
    begin
      pin_m_q <= pin_raw;
      pin_s_q <= pin_m_q;
      ck_t_prev_q <= pin_s_q[0];
      ck_c_prev_q <= pin_s_q[1];
    end
  end

  wire s_ck_t = pin_s_q[0];
  wire s_ck_c = pin_s_q[1];
  wire s_cke = pin_s_q[2];
  wire s_cs_n = pin_s_q[3];
  wire [3:0] s_cmd = pin_s_q[7:4];
  wire [2:0] s_bank = pin_s_q[10:8];
  wire s_ap = pin_s_q[11];
  wire s_bc_n = pin_s_q[12];
  wire [2:0] s_col = pin_s_q[15:13];
  wire termination_enable_s = pin_s_q[`DCIG_PIN_W-1];
  wire s_odt = termination_enable_s;

  // Sampling point: true clock rising while the complement falls
  wire ck_cross = s_ck_t & ~ck_t_prev_q & ~s_ck_c & ck_c_prev_q;

  // ----------------------------------------------------------------------
  // Registers read by software; only the mode register is written by software
  // ----------------------------------------------------------------------
  reg [`DCIG_MODE_W-1:0] mode_q;
  reg [31:0] cmd_cnt_q;
  reg [31:0] mask_cnt_q;
  reg [7:0] bank_open_q;
  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & penable & ~pwrite;
  wire addr_ok = (paddr == `DCIG_OFF_MODE) | (paddr == `DCIG_OFF_STATUS) |
                 (paddr == `DCIG_OFF_CMDCNT) | (paddr == `DCIG_OFF_MASKCNT);

  wire term_dis = mode_q[`DCIG_F_TERM_DIS];
  wire [1:0] bl_sel = mode_q[`DCIG_F_BL_HI:`DCIG_F_BL_LO];
  wire bt_ilv = mode_q[`DCIG_F_BT];
  wire [1:0] al_sel = mode_q[`DCIG_F_AL_HI:`DCIG_F_AL_LO];
  wire [4:0] rl_val = mode_q[`DCIG_F_RL_HI:`DCIG_F_RL_LO];

  // Zero-wait slave; unmapped addresses answer with an error and zero data
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_q <= `DCIG_MODE_RST;
      prdata <= `DCIG_CNT_RST;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
      if (apb_wr & pready & (paddr == `DCIG_OFF_MODE))
      begin
        mode_q <= pwdata[`DCIG_MODE_W-1:0];
      end
      if (psel & ~penable & ~pwrite)
      begin
        case (paddr)
          `DCIG_OFF_MODE: prdata <= {21'h000000, mode_q};
          `DCIG_OFF_STATUS: prdata <= {16'h0000, bank_open_q, 3'h0, nominal_termination,
                                      2'h0, power_state};
          `DCIG_OFF_CMDCNT: prdata <= cmd_cnt_q;
          `DCIG_OFF_MASKCNT: prdata <= mask_cnt_q;
          default: prdata <= `DCIG_CNT_RST;
        endcase
      end
      else if (!apb_rd)
      begin
        prdata <= `DCIG_CNT_RST;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Power state machine and bank tracking
  // ----------------------------------------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  wire any_open = |bank_open_q;
  wire cmd_live = ck_cross & ~s_cs_n & s_cke & cke_prev_q & (state_q == `DCIG_ST_NORMAL);
  wire cke_fall = ck_cross & ~s_cke & cke_prev_q;

  // Self-refresh exit looks at the gate level alone, no clock edge needed
  always @*
  begin
    state_d = state_q;
    case (state_q)
      `DCIG_ST_NORMAL:
      begin
        if (cke_fall)
        begin
          if (!s_cs_n & (s_cmd == `DCIG_CMD_REF) & !any_open)
            state_d = `DCIG_ST_SREF;
          else if (any_open)
            state_d = `DCIG_ST_APD;
          else
            state_d = `DCIG_ST_PPD;
        end
      end
      `DCIG_ST_PPD, `DCIG_ST_APD:
      begin
        if (ck_cross & s_cke)
          state_d = `DCIG_ST_NORMAL;
      end
      `DCIG_ST_SREF:
      begin
        if (s_cke)
          state_d = `DCIG_ST_NORMAL;
      end
      default: state_d = `DCIG_ST_NORMAL;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= `DCIG_ST_NORMAL;
      bank_open_q <= 8'h00;
      cke_prev_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cke_prev_q <= ck_cross ? s_cke : cke_prev_q;
      // Deselected edges never reach here, so bank state holds
      if (cmd_live & ~s_cmd[3])
        bank_open_q[s_bank] <= 1'b1;
      else if (cmd_live & (s_cmd == `DCIG_CMD_PRE))
      begin
        if (s_ap)
          bank_open_q <= 8'h00;
        else
          bank_open_q[s_bank] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Buffer gating and termination
  // ----------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      internal_clk_run <= 1'b0;
      output_drv_en <= 1'b0;
      clk_buf_en <= 1'b0;
      ctl_buf_en <= 1'b0;
      term_buf_en <= 1'b0;
      power_state <= `DCIG_ST_NORMAL;
      nominal_termination <= 1'b0;
    end
    else
    begin
      internal_clk_run <= (state_d == `DCIG_ST_NORMAL);
      output_drv_en <= (state_d == `DCIG_ST_NORMAL);
      ctl_buf_en <= (state_d == `DCIG_ST_NORMAL);
      clk_buf_en <= (state_d != `DCIG_ST_SREF);
      term_buf_en <= (state_d != `DCIG_ST_SREF);
      power_state <= state_d;
      // Termination pin taken at the sampling edge, dropped when disabled
      if (term_dis | (state_d == `DCIG_ST_SREF))
        nominal_termination <= 1'b0;
      else if (ck_cross)
        nominal_termination <= s_odt;
    end
  end

  // ----------------------------------------------------------------------
  // Access decode: burst length, order, group gating, latency
  // ----------------------------------------------------------------------
  wire is_rw = cmd_live & ((s_cmd == `DCIG_CMD_RD) | (s_cmd == `DCIG_CMD_WR));
  reg chop_d;
  reg [23:0] order_d;
  reg [4:0] al_d;
  integer i;
  reg [2:0] idx;

  // Column order within an eight-beat burst
  always @*
  begin
    order_d = 24'h000000;
    idx = 3'h0;
    for (i = 0; i < 8; i = i + 1)
    begin
      idx = i[2:0];
      if (bt_ilv)
        order_d[i*3 +: 3] = s_col ^ idx;
      else
        order_d[i*3 +: 3] = {s_col[2] ^ idx[2], s_col[1:0] + idx[1:0]};
    end
  end

  // Burst chop per access and additive latency value
  always @*
  begin
    case (bl_sel)
      `DCIG_BL_FIXED4: chop_d = 1'b1;
      `DCIG_BL_OTF: chop_d = ~s_bc_n;
      default: chop_d = 1'b0;
    endcase
    case (al_sel)
      `DCIG_AL_RL_M1: al_d = rl_val - `DCIG_RL_ONE;
      `DCIG_AL_RL_M2: al_d = rl_val - `DCIG_RL_TWO;
      default: al_d = 5'h00;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_valid <= 1'b0;
      cmd_code <= 4'h0;
      group_io_en <= 2'h0;
      burst_chop_four <= 1'b0;
      burst_order <= 24'h000000;
      additive_latency <= 5'h00;
      cmd_cnt_q <= `DCIG_CNT_RST;
      mask_cnt_q <= `DCIG_CNT_RST;
    end
    else
    begin
      cmd_valid <= cmd_live;
      additive_latency <= al_d;
      // Only the addressed group opens its data gating, for one cycle
      group_io_en <= is_rw ? (s_bank[2] ? 2'h2 : 2'h1) : 2'h0;
      if (cmd_live)
      begin
        cmd_code <= s_cmd;
        cmd_cnt_q <= cmd_cnt_q + 32'h00000001;
      end
      if (is_rw)
      begin
        burst_chop_four <= chop_d;
        burst_order <= order_d;
      end
      // Masked edges in the normal state are counted and issue no command; power state and termination still follow them
      if (ck_cross & s_cs_n & (state_q == `DCIG_ST_NORMAL))
        mask_cnt_q <= mask_cnt_q + 32'h00000001;
    end
  end

endmodule // dcig_top

// ---- verif/dcig_checker_assertions.sv ----
// Port-level checks for the control-input gating front end
`timescale 1ns/1ps
module dcig_checker
(
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  input wire clock_gate,
  input wire [1:0] power_state,
  input wire internal_clk_run,
  input wire output_drv_en,
  input wire clk_buf_en,
  input wire ctl_buf_en,
  input wire term_buf_en,
  input wire cmd_valid,
  input wire [1:0] group_io_en
);
  // ------
  // Properties
  // ------
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_en_norm;
    internal_clk_run |-> power_state == 2'h0 && output_drv_en && ctl_buf_en;
  endproperty
  a_en_norm: assert property (p_en_norm) else $error("enables on outside normal");
  property p_pd_bufs;
    power_state inside {2'h1, 2'h2} |-> clk_buf_en && term_buf_en && !ctl_buf_en;
  endproperty
  a_pd_bufs: assert property (p_pd_bufs) else $error("power-down buffers wrong");
  property p_sr_bufs;
    power_state == 2'h3 |-> !(clk_buf_en || term_buf_en || ctl_buf_en);
  endproperty
  a_sr_bufs: assert property (p_sr_bufs) else $error("self-refresh buffers on");
  property p_grp;
    group_io_en != 2'h0 |-> cmd_valid && $onehot(group_io_en) ##1 group_io_en == 2'h0;
  endproperty
  a_grp: assert property (p_grp) else $error("group gating pulse wrong");
  property p_sr_exit;
    power_state == 2'h3 && clock_gate |-> ##[1:4] power_state == 2'h0;
  endproperty
  a_sr_exit: assert property (p_sr_exit) else $error("self-refresh exit late");
  property p_pd_entry;
    $fell(ctl_buf_en) |-> !clock_gate;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("buffers off with gate high");
  property p_cmd_pulse;
    cmd_valid |=> !cmd_valid;
  endproperty
  a_cmd_pulse: assert property (p_cmd_pulse) else $error("command taken twice");
  property p_apb_rdy;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_rdy: assert property (p_apb_rdy) else $error("ready not one cycle");
  property p_err;
    pslverr |-> pready && prdata == 32'h0;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
  // Main scenarios reached
  c_sref: cover property (power_state == 2'h3);
  c_apd: cover property (power_state == 2'h2);
  c_err: cover property (pslverr);
endmodule // dcig_checker

bind dcig_top dcig_checker dcig_checker_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .clock_gate(clock_gate), .power_state(power_state), .internal_clk_run(internal_clk_run),
  .output_drv_en(output_drv_en), .clk_buf_en(clk_buf_en), .ctl_buf_en(ctl_buf_en),
  .term_buf_en(term_buf_en), .cmd_valid(cmd_valid), .group_io_en(group_io_en));

// ---- verif/dcig_ctrl_model.sv ----
// Memory controller model driving the link pins
`timescale 1ns/1ps
module dcig_ctrl_model
(
  input wire pclk,
  output reg clock_true,
  output reg clock_complement,
  output reg clock_gate,
  output reg chip_select_n,
  output reg activate_n,
  output reg [2:0] cmd_bits,
  output reg bank_group,
  output reg [1:0] bank_addr,
  output reg addr_ap,
  output reg addr_bc_n,
  output reg [2:0] addr_col,
  output reg termination_enable
);
  // Refresh bookkeeping only: one refresh window is far longer than any run
  int ref_sent = 0;
  // Parked: clock still, deselected, gate high
  initial
  begin
    {clock_true, clock_complement, clock_gate, chip_select_n} = 4'h7;
    {activate_n, cmd_bits, bank_group, bank_addr, addr_ap, addr_bc_n, addr_col} = 12'hFFF;
    termination_enable = 1'b0;
  end
  // One 160 ns link period, pins held 4 pclk either side of the rise
  task cmd(input logic cs_n, input logic [11:0] v);
    @(posedge pclk);
    chip_select_n <= cs_n;
    {activate_n, cmd_bits, bank_group, bank_addr, addr_ap, addr_bc_n, addr_col} <= v;
    if (!cs_n && v[11:8] == 4'h9)
      ref_sent++;
    repeat (4) @(posedge pclk);
    clock_true <= 1'b1;
    clock_complement <= 1'b0;
    repeat (4) @(posedge pclk);
    clock_true <= 1'b0;
    clock_complement <= 1'b1;
    chip_select_n <= 1'b1;
    // Undriven lines show the inverse, not a stale copy
    {activate_n, cmd_bits, bank_group, bank_addr, addr_ap, addr_bc_n, addr_col} <= ~v;
  endtask
  // Gate moves only between periods, never inside an access
  task gate(input logic g);
    @(posedge pclk);
    clock_gate <= g;
  endtask
  task term(input logic t);
    @(posedge pclk);
    termination_enable <= t;
  endtask
endmodule // dcig_ctrl_model

// ---- verif/dcig_bench.sv ----
// Self-checking bench for the control-input gating front end
`timescale 1ns/1ps
`include "dcig_consts.vh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module dcig_bench;
  logic pclk, presetn, psel, penable, pwrite, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [1:0] grp;
  wire [31:0] prdata;
  wire pready, pslverr, internal_clk_run, output_drv_en, clk_buf_en, ctl_buf_en, term_buf_en;
  wire nominal_termination, cmd_valid, burst_chop_four;
  wire [1:0] power_state, group_io_en, bank_addr;
  wire [3:0] cmd_code;
  wire [23:0] burst_order;
  wire [4:0] additive_latency;
  wire clock_true, clock_complement, clock_gate, chip_select_n, activate_n, bank_group;
  wire addr_ap, addr_bc_n, termination_enable;
  wire [2:0] cmd_bits, addr_col;
  int err_total = 0;
  int comparisons = 0;
  int ncmd = 0;
  dcig_top dcig_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .clock_true(clock_true), .clock_complement(clock_complement),
    .clock_gate(clock_gate), .chip_select_n(chip_select_n), .activate_n(activate_n),
    .cmd_bits(cmd_bits), .bank_group(bank_group), .bank_addr(bank_addr), .addr_ap(addr_ap),
    .addr_bc_n(addr_bc_n), .addr_col(addr_col), .termination_enable(termination_enable),
    .internal_clk_run(internal_clk_run), .output_drv_en(output_drv_en),
    .clk_buf_en(clk_buf_en), .ctl_buf_en(ctl_buf_en), .term_buf_en(term_buf_en),
    .power_state(power_state), .nominal_termination(nominal_termination),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .group_io_en(group_io_en),
    .burst_chop_four(burst_chop_four), .burst_order(burst_order),
    .additive_latency(additive_latency));
  dcig_ctrl_model ctrl (.pclk(pclk), .clock_true(clock_true),
    .clock_complement(clock_complement), .clock_gate(clock_gate),
    .chip_select_n(chip_select_n), .activate_n(activate_n), .cmd_bits(cmd_bits),
    .bank_group(bank_group), .bank_addr(bank_addr), .addr_ap(addr_ap), .addr_bc_n(addr_bc_n),
    .addr_col(addr_col), .termination_enable(termination_enable));
  // ------
  // Clock and pulse capture
  // ------
  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Latch one-cycle strobes so none is missed
  always @(posedge pclk)
  begin
    if (cmd_valid)
    begin
      ncmd <= ncmd + 1;
      grp <= group_io_en;
    end
  end
  // ------
  // Helpers
  // ------
  task close_out;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int n = 0; n < 9 && pready !== 1'b1; n++)
      @(posedge pclk);
    if (pready !== 1'b1)
    begin
      err_total++;
      close_out;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Link period plus settling through the synchronisers
  task lk(input logic cs_n, input logic [11:0] v);
    ctrl.cmd(cs_n, v);
    repeat (2) @(posedge pclk);
  endtask
  // Sequential adds in the low two bits; interleave is plain XOR
  function automatic logic [23:0] ord(input logic [2:0] c, input logic il);
    for (int i = 0; i < 8; i++)
      ord[i*3 +: 3] = il ? c ^ i[2:0] : {c[2] ^ i[2], c[1:0] + i[1:0]};
  endfunction
  // ------
  // Scenarios
  // ------
  task regs;
    `CHK(internal_clk_run, 1'b1)
    apb(1'b0, `DCIG_OFF_MODE, 32'h0);
    `CHK(q, `DCIG_MODE_RST)
    apb(1'b1, 12'h010, 32'hFFFFFFFF);
    `CHK({e, q}, 33'h100000000)
    apb(1'b0, `DCIG_OFF_MODE, 32'h0);
    `CHK(q, `DCIG_MODE_RST)
    $display("regs done");
  endtask
  task cmds;
    lk(1'b0, 12'h3C8);
    `CHK(cmd_code, 4'h3)
    lk(1'b1, 12'h028);
    `CHK(ncmd, 1)
    `CHK(cmd_code, 4'h3)
    apb(1'b0, `DCIG_OFF_STATUS, 32'h0);
    `CHK(q, 32'h00004000)
    apb(1'b0, `DCIG_OFF_MASKCNT, 32'h0);
    `CHK(q, 32'h1)
    $display("cmds done");
  endtask
  task burst(input logic [31:0] m, input logic [11:0] v, input logic il, input logic ch,
    input logic [4:0] al);
    int n0;
    apb(1'b1, `DCIG_OFF_MODE, m);
    n0 = ncmd;
    lk(1'b0, v);
    `CHK(ncmd, n0 + 1)
    `CHK(grp, v[7] ? 2'h2 : 2'h1)
    `CHK(cmd_code, v[11:8])
    `CHK(burst_order, ord(3'h3, il))
    `CHK(burst_chop_four, ch)
    `CHK(additive_latency, al)
    $display("burst done");
  endtask
  task power;
    ctrl.gate(1'b0);
    lk(1'b1, 12'hFFF);
    `CHK(power_state, `DCIG_ST_APD)
    `CHK({internal_clk_run, output_drv_en, ctl_buf_en, clk_buf_en, term_buf_en}, 5'h03)
    ctrl.gate(1'b1);
    lk(1'b1, 12'hFFF);
    `CHK({internal_clk_run, output_drv_en, ctl_buf_en, clk_buf_en, term_buf_en}, 5'h1F)
    lk(1'b0, 12'hA18);
    ctrl.gate(1'b0);
    lk(1'b1, 12'hFFF);
    `CHK(power_state, `DCIG_ST_PPD)
    ctrl.gate(1'b1);
    lk(1'b1, 12'hFFF);
    ctrl.gate(1'b0);
    lk(1'b0, 12'h908);
    `CHK(power_state, `DCIG_ST_SREF)
    `CHK({clk_buf_en, term_buf_en, ctl_buf_en}, 3'h0)
    ctrl.gate(1'b1);
    for (int n = 0; n < 8 && power_state !== `DCIG_ST_NORMAL; n++)
      @(posedge pclk);
    `CHK(power_state, `DCIG_ST_NORMAL)
    if (power_state !== `DCIG_ST_NORMAL)
      close_out;
    $display("power done");
  endtask
  task term;
    ctrl.term(1'b1);
    lk(1'b1, 12'hFFF);
    `CHK(nominal_termination, 1'b1)
    apb(1'b1, `DCIG_OFF_MODE, 32'h1);
    lk(1'b1, 12'hFFF);
    `CHK(nominal_termination, 1'b0)
    $display("term done");
  endtask
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 48'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    regs;
    cmds;
    burst(32'h140, 12'hDCB, 1'b0, 1'b0, 5'h0);
    burst(32'h15C, 12'hCCB, 1'b1, 1'b1, 5'h4);
    burst(32'h162, 12'hD43, 1'b0, 1'b1, 5'h3);
    power;
    term;
    close_out;
  end
endmodule // dcig_bench
